// *** pkg/rbr_pkg.sv ***
/*
  Constants shared by the printer ready/busy reporter and its status transmitter.
  Assumes a single 50 MHz clock and a word-addressed Avalon-MM register port.
*/
`default_nettype none
package rbr_pkg;
  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int DEFAULT_BAUD = 9600;
  localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / DEFAULT_BAUD);
  localparam logic [15:0] BAUD_DIV_MIN = 16'h0002;

  // ----------------------------------------------------------------------
  // Flow-control characters and frame shape.
  // ----------------------------------------------------------------------
  localparam logic [7:0] CHAR_READY = 8'h11;
  localparam logic [7:0] CHAR_BUSY = 8'h13;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // Line levels: MARK is the low level on both status outputs.
  localparam logic LINE_MARK = 1'b0;
  localparam logic LINE_SPACE = 1'b1;

  // ----------------------------------------------------------------------
  // Register map, word indices.
  // ----------------------------------------------------------------------
  localparam logic [1:0] REG_BAUD_DIV = 2'h0;
  localparam logic [1:0] REG_CONTROL = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;

  // Control fields.
  localparam int CTL_REPORT_EN = 0;
  localparam int CTL_RESEND = 1;
  localparam logic CTL_REPORT_EN_RESET = 1'b1;

  // Status fields.
  localparam int ST_READY = 0;
  localparam int ST_OFFLINE = 1;
  localparam int ST_PAPER_OUT = 2;
  localparam int ST_JAM = 3;
  localparam int ST_BUF_FULL = 4;
  localparam int ST_CHAR_MODE = 5;
  localparam int ST_INVERT = 6;
  localparam int ST_LONG_LINE = 7;
  localparam int ST_TX_BUSY = 8;
  localparam int ST_MODEM_LO = 9;
  localparam int ST_RX_ENABLE = 12;
  localparam int ST_REPORTED = 13;

  localparam int MODEM_LINES = 3;

  typedef enum logic [1:0] {
    RBR_TX_IDLE = 2'b00,
    RBR_TX_START = 2'b01,
    RBR_TX_DATA = 2'b11,
    RBR_TX_STOP = 2'b10
  } rbr_tx_state_type;
endpackage : rbr_pkg
`default_nettype wire

// *** rtl/rbr_char_tx.sv ***
/*
  Asynchronous character transmitter for the status pair: 8 data bits,
  least significant first, one start and one stop bit.
  Assumes the caller holds i_start for one cycle only while o_busy is low.
*/
`timescale 1ns/1ns
`default_nettype none
module rbr_char_tx
  import rbr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [15:0] i_bit_div,
  input wire logic i_start,
  input wire logic [7:0] i_char,
  output logic o_busy,
  output logic o_mark
);
  rbr_tx_state_type state;
  logic [15:0] bit_count;
  logic [2:0] bit_index;
  logic [7:0] shift;
  logic bit_end;

  assign bit_end = (bit_count == 16'h0000);
  assign o_busy = (state != RBR_TX_IDLE);

  // ----------------------------------------------------------------------
  // Bit-period divider: one-cycle enable at the end of each bit.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || state == RBR_TX_IDLE || bit_end) begin
      bit_count <= i_bit_div - 16'h0001;
    end else begin
      bit_count <= bit_count - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Frame sequence.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state <= RBR_TX_IDLE;
      bit_index <= 3'h0;
      shift <= 8'h00;
    end else begin
      case (state)
        RBR_TX_IDLE: begin
          if (i_start) begin
            shift <= i_char;
            bit_index <= 3'h0;
            state <= RBR_TX_START;
          end
        end
        RBR_TX_START: begin
          if (bit_end) begin
            state <= RBR_TX_DATA;
          end
        end
        RBR_TX_DATA: begin
          if (bit_end) begin
            shift <= {1'b0, shift[7:1]};
            bit_index <= bit_index + 3'h1;
            if (bit_index == LAST_DATA_BIT) begin
              state <= RBR_TX_STOP;
            end
          end
        end
        RBR_TX_STOP: begin
          if (bit_end) begin
            state <= RBR_TX_IDLE;
          end
        end
        default: begin
          state <= RBR_TX_IDLE;
        end
      endcase
    end
  end

  // Registered line: the idle and stop levels are MARK, the start bit SPACE.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_mark <= 1'b1;
    end else begin
      case (state)
        RBR_TX_START: o_mark <= 1'b0;
        RBR_TX_DATA: o_mark <= shift[0];
        default: o_mark <= 1'b1;
      endcase
    end
  end
endmodule : rbr_char_tx
`default_nettype wire

// *** rtl/rbr_reporter.sv ***
/*
  Printer ready/busy reporter: derives ready/busy from the printer condition,
  drives the status pair of the long-line link and the standard serial
  ready/busy line, and treats floating modem-control inputs.
  Assumes straps are stable while i_resetn is low and that the register
  port is an Avalon-MM slave on i_mclk.
*/
// Notes on behaviour
// - Busy whenever offline, out of paper, carriage jammed or receive buffer full.
// - Ready only while online and able to accept and print data.
// - In break-on-busy mode the status line is MARK (low) when ready, SPACE when busy.
// - With inverted polarity the serial ready/busy line is MARK when busy, SPACE when ready.
// - In character mode a DC1 is sent on a change to ready, a DC3 on a change to busy, unless the change is undone while a character is on the line.
// - Level or character reporting is picked by a static board strap.
// - Status is sent on its own pair, independent of reception; the host keeps loops apart.
// - With the long-line option fitted, unconnected modem inputs read as asserted.
// - The polarity choice for the serial line leaves the loop status output unchanged.
`timescale 1ns/1ns
`default_nettype none
module rbr_reporter
  import rbr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Printer condition.
  input wire logic i_online,
  input wire logic i_paper_out,
  input wire logic i_carriage_jam,
  input wire logic i_rx_buffer_full,
  // Board straps, caught during reset.
  input wire logic i_strap_char_mode,
  input wire logic i_strap_inverted_status_polarity,
  input wire logic i_strap_long_line,
  // Modem-control inputs and their connected sense.
  input wire logic i_data_set_ready,
  input wire logic i_carrier_detect,
  input wire logic i_clear_to_send,
  input wire logic i_data_set_ready_connected,
  input wire logic i_carrier_detect_connected,
  input wire logic i_clear_to_send_connected,
  // Avalon-MM slave.
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Line side.
  output logic o_loop_status,
  output logic o_serial_ready_busy,
  output logic o_modem_dsr,
  output logic o_modem_dcd,
  output logic o_modem_cts,
  output logic o_rx_enable
);
  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic char_mode;
  logic invert;
  logic long_line;
  logic busy;
  logic ready;
  logic reported_ready;
  logic [15:0] baud_div;
  logic report_en;
  logic resend_req;
  logic report_due;
  logic tx_start;
  logic tx_busy;
  logic tx_mark;
  logic [7:0] tx_char;
  logic avs_ack;
  logic avs_req;
  logic [MODEM_LINES-1:0] modem_raw;
  logic [MODEM_LINES-1:0] modem_conn;
  logic [MODEM_LINES-1:0] modem_eff;
  logic [31:0] next_readdata;
  logic [31:0] status_word;

  // A floating input counts as asserted only when the option is fitted.
  function automatic logic modem_level(input logic level, input logic connected,
                                       input logic option_fitted);
    modem_level = (option_fitted && !connected) ? 1'b1 : level;
  endfunction : modem_level

  // Byte-lane merge for a 16-bit field.
  function automatic logic [15:0] merge16(input logic [15:0] old_value,
                                          input logic [15:0] new_value,
                                          input logic [1:0] lanes);
    merge16 = {lanes[1] ? new_value[15:8] : old_value[15:8],
               lanes[0] ? new_value[7:0] : old_value[7:0]};
  endfunction : merge16

  // A write lands in the first cycle of its request only.
  function automatic logic write_hit(input logic [1:0] index);
    write_hit = avs_req && i_avs_write && (i_avs_address == index);
  endfunction : write_hit

  // ----------------------------------------------------------------------
  // Board configuration.
  // ----------------------------------------------------------------------
  // The straps are sampled only while reset is held, so a jumper moved in
  // service takes effect at the next reset and never mid-character.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      char_mode <= i_strap_char_mode;
      invert <= i_strap_inverted_status_polarity;
      long_line <= i_strap_long_line;
    end
  end

  // ----------------------------------------------------------------------
  // Ready/busy condition.
  // ----------------------------------------------------------------------
  // Ready is the plain complement of busy, so the two never disagree.
  always_comb begin
    busy = !i_online || i_paper_out || i_carriage_jam || i_rx_buffer_full;
    ready = !busy;
  end

  // ----------------------------------------------------------------------
  // Modem-control inputs.
  // ----------------------------------------------------------------------
  // Levels are high when asserted; a connected sense is high when wired.
  assign modem_raw = {i_clear_to_send, i_carrier_detect, i_data_set_ready};
  assign modem_conn = {i_clear_to_send_connected, i_carrier_detect_connected,
                       i_data_set_ready_connected};

  // One registered copy feeds the outputs, the status word and rx enable.
  for (genvar g = 0; g < MODEM_LINES; g++) begin : g_modem
    always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
        modem_eff[g] <= 1'b0;
      end else begin
        modem_eff[g] <= modem_level(modem_raw[g], modem_conn[g], long_line);
      end
    end
  end

  assign o_modem_dsr = modem_eff[0];
  assign o_modem_dcd = modem_eff[1];
  assign o_modem_cts = modem_eff[2];
  // Reception is gated only by the modem lines, never by status sending.
  assign o_rx_enable = &modem_eff;

  // ----------------------------------------------------------------------
  // Character reporting.
  // ----------------------------------------------------------------------
  // The reported state follows the printer state one character at a time.
  // A change that is undone while a character is still on the line is not
  // reported, which keeps the host's last character equal to the truth.
  // The character always names the state at the moment it starts.
  assign tx_char = ready ? CHAR_READY : CHAR_BUSY;
  assign report_due = (ready != reported_ready) || resend_req;
  assign tx_start = char_mode && report_en && !tx_busy && report_due;

  // Reset leaves the reported state busy, so a ready printer announces
  // itself with a character as soon as reset ends.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      reported_ready <= 1'b0;
    end else if (tx_start) begin
      reported_ready <= ready;
    end
  end

  // The divisor is reloaded at each bit end, so a rate written mid-character
  // changes only the bits still to come.
  rbr_char_tx u_char_tx (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_bit_div(baud_div),
    .i_start(tx_start),
    .i_char(tx_char),
    .o_busy(tx_busy),
    .o_mark(tx_mark)
  );

  // ----------------------------------------------------------------------
  // Line outputs.
  // ----------------------------------------------------------------------
  // The loop pair never sees the polarity strap; only the standard serial
  // ready/busy line is inverted by it.
  // In character mode the loop idles at MARK between characters.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_loop_status <= LINE_SPACE;
    end else if (char_mode) begin
      o_loop_status <= tx_mark ? LINE_MARK : LINE_SPACE;
    end else begin
      o_loop_status <= ready ? LINE_MARK : LINE_SPACE;
    end
  end

  // Both lines rest at SPACE in reset, which the host reads as busy except on an inverted serial line, where SPACE means ready.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_serial_ready_busy <= LINE_SPACE;
    end else if (invert) begin
      o_serial_ready_busy <= ready ? LINE_SPACE : LINE_MARK;
    end else begin
      o_serial_ready_busy <= ready ? LINE_MARK : LINE_SPACE;
    end
  end

  // ----------------------------------------------------------------------
  // Register port.
  // ----------------------------------------------------------------------
  // Every access takes exactly one wait cycle; the ack flop answers in the
  // second cycle of the request and then lets the master release it.
  // A request raised right after release waits one cycle like the first.
  assign avs_req = (i_avs_read || i_avs_write) && !avs_ack;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !avs_ack;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      avs_ack <= 1'b0;
    end else begin
      avs_ack <= avs_req;
    end
  end

  // ----------------------------------------------------------------------
  // Divisor and control registers.
  // ----------------------------------------------------------------------
  // Lanes 3:2 of the divisor word read as zero and ignore writes.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      baud_div <= BAUD_DIV_RESET;
    end else if (write_hit(REG_BAUD_DIV)) begin
      // Too short a bit period would stall the frame, so it is clamped.
      if (merge16(baud_div, i_avs_writedata[15:0], i_avs_byteenable[1:0])
          < BAUD_DIV_MIN) begin
        baud_div <= BAUD_DIV_MIN;
      end else begin
        baud_div <= merge16(baud_div, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
      end
    end
  end

  // Clearing the enable stops new characters; one already started finishes.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      report_en <= CTL_REPORT_EN_RESET;
    end else if (write_hit(REG_CONTROL) && i_avs_byteenable[0]) begin
      report_en <= i_avs_writedata[CTL_REPORT_EN];
    end
  end

  // A resend request waits for the line; the write that sets it wins over
  // the start that would clear it in the same cycle.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      resend_req <= 1'b0;
    end else if (write_hit(REG_CONTROL) && i_avs_byteenable[0] &&
                 i_avs_writedata[CTL_RESEND]) begin
      resend_req <= 1'b1;
    end else if (tx_start || !char_mode) begin
      resend_req <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------------
  // Status shows the live condition that also drives the lines.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_READY] = ready;
    status_word[ST_OFFLINE] = !i_online;
    status_word[ST_PAPER_OUT] = i_paper_out;
    status_word[ST_JAM] = i_carriage_jam;
    status_word[ST_BUF_FULL] = i_rx_buffer_full;
    status_word[ST_CHAR_MODE] = char_mode;
    status_word[ST_INVERT] = invert;
    status_word[ST_LONG_LINE] = long_line;
    status_word[ST_TX_BUSY] = tx_busy;
    status_word[ST_MODEM_LO +: MODEM_LINES] = modem_eff;
    status_word[ST_RX_ENABLE] = &modem_eff;
    status_word[ST_REPORTED] = reported_ready;
  end

  // The unmapped word reads as zero and matches no write decode.
  always_comb begin
    case (i_avs_address)
      REG_BAUD_DIV: next_readdata = {16'h0000, baud_div};
      REG_CONTROL: next_readdata = {31'h0000_0000, report_en};
      REG_STATUS: next_readdata = status_word;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (avs_req && i_avs_read) begin
      o_avs_readdata <= next_readdata;
    end
  end
endmodule : rbr_reporter
`default_nettype wire

// *** dv/rbr_reporter_asserts.sv ***
/*
  Port checker for the ready/busy reporter.
  Assumes the straps move only while reset is low.
*/
`timescale 1ns/1ns
`default_nettype none
module rbr_reporter_asserts
  import rbr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_online,
  input wire logic i_paper_out,
  input wire logic i_carriage_jam,
  input wire logic i_rx_buffer_full,
  input wire logic i_strap_char_mode,
  input wire logic i_strap_inverted_status_polarity,
  input wire logic i_strap_long_line,
  input wire logic i_data_set_ready_connected,
  input wire logic i_carrier_detect,
  input wire logic i_carrier_detect_connected,
  input wire logic o_loop_status,
  input wire logic o_serial_ready_busy,
  input wire logic o_modem_dsr,
  input wire logic o_modem_dcd,
  input wire logic o_modem_cts,
  input wire logic o_rx_enable
);
  logic cm_s;
  logic inv_s;
  logic long_s;
  wire logic rdy = i_online & ~i_paper_out & ~i_carriage_jam & ~i_rx_buffer_full;

  // ----------------------------------------------------------------------
  // Strap copies and properties.
  // ----------------------------------------------------------------------
  // Straps are caught only in reset, so a strap moved later must change nothing.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      cm_s <= i_strap_char_mode;
      inv_s <= i_strap_inverted_status_polarity;
      long_s <= i_strap_long_line;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_busy_space;
    (!cm_s && $past(i_resetn) && !$past(rdy)) |-> o_loop_status == LINE_SPACE;
  endproperty
  a_busy_space: assert property (p_busy_space) else $error("loop not space when busy");
  property p_ready_mark;
    (!cm_s && $past(i_resetn) && $past(rdy)) |-> o_loop_status == LINE_MARK;
  endproperty
  a_ready_mark: assert property (p_ready_mark) else $error("loop not mark when ready");
  property p_serial_normal;
    (!inv_s && $past(i_resetn)) |-> o_serial_ready_busy == !$past(rdy);
  endproperty
  a_serial_normal: assert property (p_serial_normal) else $error("serial line level");
  property p_serial_inv;
    (inv_s && $past(i_resetn)) |-> o_serial_ready_busy == $past(rdy);
  endproperty
  a_serial_inv: assert property (p_serial_inv) else $error("inverted serial level");
  property p_loop_plain;
    (inv_s && !cm_s && $past(i_resetn)) |-> o_loop_status != o_serial_ready_busy;
  endproperty
  a_loop_plain: assert property (p_loop_plain) else $error("loop output inverted");
  property p_dsr_float;
    (long_s && $past(i_resetn) && !$past(i_data_set_ready_connected)) |-> o_modem_dsr;
  endproperty
  a_dsr_float: assert property (p_dsr_float) else $error("floating input not on");
  property p_dcd_follow;
    ((!long_s || $past(i_carrier_detect_connected)) && $past(i_resetn))
      |-> o_modem_dcd == $past(i_carrier_detect);
  endproperty
  a_dcd_follow: assert property (p_dcd_follow) else $error("modem level not raw");
  property p_rx_enable;
    o_rx_enable == (o_modem_dsr & o_modem_dcd & o_modem_cts);
  endproperty
  a_rx_enable: assert property (p_rx_enable) else $error("receive enable wrong");
endmodule : rbr_reporter_asserts

bind rbr_reporter rbr_reporter_asserts u_asserts (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_online(i_online), .i_paper_out(i_paper_out),
  .i_carriage_jam(i_carriage_jam), .i_rx_buffer_full(i_rx_buffer_full),
  .i_strap_char_mode(i_strap_char_mode),
  .i_strap_inverted_status_polarity(i_strap_inverted_status_polarity),
  .i_strap_long_line(i_strap_long_line),
  .i_data_set_ready_connected(i_data_set_ready_connected),
  .i_carrier_detect(i_carrier_detect), .i_carrier_detect_connected(i_carrier_detect_connected),
  .o_loop_status(o_loop_status), .o_serial_ready_busy(o_serial_ready_busy),
  .o_modem_dsr(o_modem_dsr), .o_modem_dcd(o_modem_dcd), .o_modem_cts(o_modem_cts),
  .o_rx_enable(o_rx_enable)
);
`default_nettype wire

// *** dv/rbr_host_rx.sv ***
/*
  Host model that listens on the status pair and decodes 8N1 characters.
  Assumes its bit length matches the divisor written into the block.
*/
`timescale 1ns/1ns
`default_nettype none
module rbr_host_rx
  import rbr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_line,
  input wire logic [15:0] i_bit_div,
  output var int o_count,
  output var int o_bad,
  output logic [7:0] o_char
);
  logic prev;
  logic [7:0] data;

  // ----------------------------------------------------------------------
  // Frame decoder.
  // ----------------------------------------------------------------------
  // The host only listens here and never loops status back to data.
  initial begin
    o_count = 0;
    o_bad = 0;
    o_char = 8'h00;
    prev = LINE_SPACE;
    forever begin
      @(posedge i_mclk);
      // A step from MARK to SPACE outside reset opens a frame.
      if (i_resetn && prev === LINE_MARK && i_line === LINE_SPACE) begin
        repeat (i_bit_div / 2 - 1) @(posedge i_mclk);
        if (i_line !== LINE_SPACE) o_bad++;
        for (int b = 0; b < 8; b++) begin
          repeat (i_bit_div) @(posedge i_mclk);
          data[b] = (i_line === LINE_MARK);
        end
        repeat (i_bit_div) @(posedge i_mclk);
        if (i_line !== LINE_MARK) o_bad++;
        else begin
          o_char = data;
          o_count++;
        end
      end
      prev = i_line;
    end
  end
endmodule : rbr_host_rx
`default_nettype wire

// *** dv/rbr_reporter_tb_top.sv ***
/*
  Self-checking bench for the ready/busy reporter.
  Assumes the host model decodes at the divisor the bench writes.
*/
`timescale 1ns/1ns
`default_nettype none
module rbr_reporter_tb_top
  import rbr_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_resetn, i_online, i_paper_out, i_carriage_jam, i_rx_buffer_full;
  logic i_strap_char_mode, i_strap_inverted_status_polarity, i_strap_long_line;
  logic i_data_set_ready, i_carrier_detect, i_clear_to_send, dsr_con, dcd_con, cts_con;
  logic [1:0] i_avs_address;
  logic i_avs_read, i_avs_write, o_avs_waitrequest, o_loop_status, o_serial_ready_busy;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  logic [3:0] i_avs_byteenable;
  logic o_modem_dsr, o_modem_dcd, o_modem_cts, o_rx_enable;
  logic [7:0] rx_char;
  logic host_on = 1'b0;
  logic [5:0] rows [6];
  int errors = 0;
  int checks_done = 0;
  int rx_count, rx_bad;

  rbr_reporter u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_online(i_online),
    .i_paper_out(i_paper_out), .i_carriage_jam(i_carriage_jam),
    .i_rx_buffer_full(i_rx_buffer_full), .i_strap_char_mode(i_strap_char_mode),
    .i_strap_inverted_status_polarity(i_strap_inverted_status_polarity),
    .i_strap_long_line(i_strap_long_line), .i_data_set_ready(i_data_set_ready),
    .i_carrier_detect(i_carrier_detect), .i_clear_to_send(i_clear_to_send),
    .i_data_set_ready_connected(dsr_con), .i_carrier_detect_connected(dcd_con),
    .i_clear_to_send_connected(cts_con), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_loop_status(o_loop_status),
    .o_serial_ready_busy(o_serial_ready_busy), .o_modem_dsr(o_modem_dsr),
    .o_modem_dcd(o_modem_dcd), .o_modem_cts(o_modem_cts), .o_rx_enable(o_rx_enable));
  rbr_host_rx u_host (.i_mclk(i_mclk), .i_resetn(i_resetn && host_on), .i_line(o_loop_status),
    .i_bit_div(16'h0010), .o_count(rx_count), .o_bad(rx_bad), .o_char(rx_char));

  always #10 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : check

  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_mclk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus

  task automatic do_reset(input logic cm, input logic inv, input logic lng);
    i_strap_char_mode <= cm;
    i_strap_inverted_status_polarity <= inv;
    i_strap_long_line <= lng;
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
  endtask : do_reset

  task automatic wait_rx(input int want, input logic [7:0] ch);
    int n;
    n = 0;
    while (rx_count != want && n < 400) begin
      @(posedge i_mclk);
      n++;
    end
    check(rx_count, want);
    check(rx_char, ch);
  endtask : wait_rx

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    {i_online, i_paper_out, i_carriage_jam, i_rx_buffer_full} = 4'h0;
    {i_data_set_ready, i_carrier_detect, i_clear_to_send} = 3'h0;
    {dsr_con, dcd_con, cts_con} = 3'h3;
    {i_avs_address, i_avs_read, i_avs_write, i_avs_writedata} = '0;
    i_avs_byteenable = 4'hf;
    // Rows: online, paper out, jam, buffer full, loop level, serial level.
    rows = '{6'b1000_01, 6'b0000_10, 6'b1100_10, 6'b1010_10, 6'b1001_10, 6'b1111_10};
    do_reset(1'b0, 1'b1, 1'b1);
    bus(1'b0, REG_BAUD_DIV, 32'h0);
    check(rd, {16'h0000, BAUD_DIV_RESET});
    bus(1'b1, REG_CONTROL, 32'h3);
    bus(1'b0, REG_CONTROL, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, 2'h3, 32'hffffffff);
    bus(1'b0, 2'h3, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, REG_BAUD_DIV, 32'h1);
    bus(1'b0, REG_BAUD_DIV, 32'h0);
    check(rd, {16'h0000, BAUD_DIV_MIN});
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h000000e0, 32'h000000c0);
    for (int r = 0; r < 6; r++) begin
      {i_online, i_paper_out, i_carriage_jam, i_rx_buffer_full} <= rows[r][5:2];
      repeat (3) @(posedge i_mclk);
      check(o_loop_status, rows[r][1]);
      check(o_serial_ready_busy, rows[r][0]);
    end
    check(o_modem_dsr, 1'b1);
    {i_carrier_detect, i_clear_to_send} <= 2'h3;
    repeat (3) @(posedge i_mclk);
    check(o_rx_enable, 1'b1);
    // Character mode; strap moved after reset must be ignored.
    {i_online, i_paper_out, i_carriage_jam, i_rx_buffer_full} <= 4'h0;
    do_reset(1'b1, 1'b0, 1'b0);
    i_strap_char_mode <= 1'b0;
    // Level-mode steps are no frames, so the host listens from here on.
    host_on <= 1'b1;
    bus(1'b1, REG_BAUD_DIV, 32'h10);
    check(o_modem_dsr, 1'b0);
    i_online <= 1'b1;
    wait_rx(1, CHAR_READY);
    check(o_serial_ready_busy, LINE_MARK);
    i_online <= 1'b0;
    wait_rx(2, CHAR_BUSY);
    // A change undone while a character is on the line is not reported.
    i_online <= 1'b1;
    repeat (40) @(posedge i_mclk);
    i_online <= 1'b0;
    repeat (40) @(posedge i_mclk);
    i_online <= 1'b1;
    wait_rx(3, CHAR_READY);
    repeat (300) @(posedge i_mclk);
    check(rx_count, 32'd3);
    i_paper_out <= 1'b1;
    wait_rx(4, CHAR_BUSY);
    bus(1'b1, REG_CONTROL, 32'h3);
    wait_rx(5, CHAR_BUSY);
    bus(1'b1, REG_CONTROL, 32'h0);
    i_paper_out <= 1'b0;
    repeat (300) @(posedge i_mclk);
    check(rx_count, 32'd5);
    check(rx_bad, 32'd0);
    conclude();
  end
endmodule : rbr_reporter_tb_top
`default_nettype wire
